/* shared/mpb_defines.vh */
// Constants for the memory and peripheral bus port.
// Included by the port module only; definitions only.
`ifndef MPB_DEFINES_VH
`define MPB_DEFINES_VH

// Bus widths
`define MPB_DATA_W 8
`define MPB_ADDR_W 26
`define MPB_PIN_ADDR_W 22
`define MPB_HI_ADDR_W 4
`define MPB_CS_N 4
`define MPB_CS_IDX_W 2

// Timing field widths
`define MPB_WS_W 6
`define MPB_PD_W 5
`define MPB_CNT_W 7

// Extra strobe cycles covering the three-stage input synchroniser
`define MPB_SYNC_SLACK 7'h03

// Request word layout: write flag, chip select index, address, data
`define MPB_REQ_W 37
`define MPB_REQ_WR_POS 36
`define MPB_REQ_CS_HI 35
`define MPB_REQ_CS_LO 34
`define MPB_REQ_ADDR_HI 33
`define MPB_REQ_ADDR_LO 8
`define MPB_REQ_DATA_HI 7
`define MPB_REQ_DATA_LO 0

// Request queue geometry
`define MPB_FIFO_DEPTH 4
`define MPB_FIFO_AW 2

// Reset values of pin-facing registers and the sequencer counter
`define MPB_CS_IDLE 4'hF
`define MPB_ADDR_RST 22'h000000
`define MPB_DATA_RST 8'h00
`define MPB_CNT_RST 7'h00

`endif

/* src/mpb_sync.v */
// Three-stage input synchroniser with agreement filter.
// Assumes its input is asynchronous to i_sys_clk; output moves only when
// the second and third stages agree.
`timescale 1ns/10ps
module mpb_sync #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] s1_q; // First stage, read only by the second
  reg [W-1:0] s2_q; // Second stage
  reg [W-1:0] s3_q; // Third stage

  // Free-running chain; no reset so the pins pass even during reset
  always @(posedge i_sys_clk) begin
    s1_q <= i_async;
    s2_q <= s1_q;
    s3_q <= s2_q;
    // Only a level seen on two successive stages is accepted
    if (s2_q == s3_q) begin
      o_sync <= s3_q;
    end
  end
endmodule // mpb_sync

/* src/mpb_fifo.v */
// Request queue: flip-flop storage indexed by read and write pointers.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mpb_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_q [0:D-1]; // Storage words
  reg [AW-1:0] wr_q; // Write index
  reg [AW-1:0] rd_q; // Read index
  reg [AW:0] cnt_q; // Words held
  wire push; // Word accepted this cycle
  wire pop; // Word drained this cycle

  assign o_in_ready = (cnt_q != D[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Pointer and count upkeep; wraps rely on D being a power of two
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage write; contents need no reset
  always @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule // mpb_fifo

/* src/mpb_port.v */
// Memory and peripheral bus port: turns queued byte requests into
// pin-level cycles for SRAM, flash, ROM and peripherals.
// Assumes one 50 MHz clock, synchronous reset, and a board that resolves
// the data pins from o_mem_bus_data_oe and presents the boot vector.
`timescale 1ns/10ps
`include "mpb_defines.vh"
module mpb_port (
  input wire i_sys_clk,
  input wire i_srst,
  // Request side
  input wire i_req_valid,
  output wire o_req_ready,
  input wire i_req_write,
  input wire [`MPB_CS_IDX_W-1:0] i_req_cs,
  input wire [`MPB_ADDR_W-1:0] i_req_addr,
  input wire [`MPB_DATA_W-1:0] i_req_wdata,
  // Answer side
  output reg o_rsp_valid,
  output reg o_rsp_write,
  output reg o_rsp_protect_err,
  output reg [`MPB_DATA_W-1:0] o_rsp_rdata,
  // Configuration and status
  input wire [`MPB_WS_W-1:0] i_cfg_wait_states,
  input wire [`MPB_PD_W-1:0] i_cfg_post_delay,
  input wire i_cfg_ack_mode,
  input wire [`MPB_CS_N-1:0] i_cfg_write_protect,
  output wire o_busy,
  output reg [`MPB_DATA_W-1:0] o_boot_vector,
  // Bus pins
  output reg [`MPB_PIN_ADDR_W-1:0] o_mem_bus_address,
  output reg [`MPB_HI_ADDR_W-1:0] o_mem_bus_address_hi,
  output reg [`MPB_CS_N-1:0] o_chip_select_low,
  output reg o_read_not_write,
  output reg o_output_enable_low,
  output reg o_write_strobe_low,
  output reg o_xcvr_direction,
  output reg o_xcvr_enable_low,
  input wire [`MPB_DATA_W-1:0] i_mem_bus_data,
  output reg [`MPB_DATA_W-1:0] o_mem_bus_data,
  output reg o_mem_bus_data_oe,
  input wire i_wait_or_ack_in
);

  // ************************************************************
  // Local definitions
  // ************************************************************

  // One-hot bus cycle states
  localparam [4:0] ST_IDLE = 5'h01; // Waiting for a request
  localparam [4:0] ST_SETUP = 5'h02; // Address and select settle
  localparam [4:0] ST_STROBE = 5'h04; // Strobe and wait states
  localparam [4:0] ST_HANDSHAKE = 5'h08; // Waiting on the far device
  localparam [4:0] ST_POST = 5'h10; // Recovery gap

  // Chip select index to active-low select pattern
  function [`MPB_CS_N-1:0] cs_decode;
    input [`MPB_CS_IDX_W-1:0] idx;
    begin
      cs_decode = ~(4'h1 << idx);
    end
  endfunction

  // ************************************************************
  // Request queue
  // ************************************************************

  wire q_valid; // Queued request present
  wire q_pop; // Request taken by the sequencer
  wire [`MPB_REQ_W-1:0] q_word; // Head request
  wire [`MPB_REQ_W-1:0] in_word; // Packed incoming request

  assign in_word = {i_req_write, i_req_cs, i_req_addr, i_req_wdata};

  // Queue lets software post writes while a slow device is busy
  mpb_fifo #(
    .W(`MPB_REQ_W),
    .D(`MPB_FIFO_DEPTH),
    .AW(`MPB_FIFO_AW)
  ) u_queue (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_in_valid(i_req_valid),
    .o_in_ready(o_req_ready),
    .i_in_data(in_word),
    .o_out_valid(q_valid),
    .i_out_ready(q_pop),
    .o_out_data(q_word)
  );

  // ************************************************************
  // Pin input synchronisers
  // ************************************************************

  wire [`MPB_DATA_W-1:0] data_sync; // Filtered data pins
  wire wait_ack_sync; // Filtered handshake pin, still active low

  // Data pins feed both read capture and boot capture
  mpb_sync #(
    .W(`MPB_DATA_W)
  ) u_data_sync (
    .i_sys_clk(i_sys_clk),
    .i_async(i_mem_bus_data),
    .o_sync(data_sync)
  );

  // Wait or acknowledge line
  mpb_sync #(
    .W(1)
  ) u_wait_sync (
    .i_sys_clk(i_sys_clk),
    .i_async(i_wait_or_ack_in),
    .o_sync(wait_ack_sync)
  );

  wire handshake_on; // Handshake pin asserted
  assign handshake_on = ~wait_ack_sync;

  // ************************************************************
  // Boot configuration capture
  // ************************************************************

  reg rst_q; // Reset seen at the previous edge

  // Tracks the pins through reset and one edge past it. The filter lags
  // the pins by about four edges, so the value taken one edge after release
  // still shows reset-time levels; a four-edge reset is then enough
  always @(posedge i_sys_clk) begin
    rst_q <= i_srst;
    if (i_srst | rst_q) begin
      o_boot_vector <= data_sync;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************

  reg [4:0] state_q; // Current state
  reg [`MPB_CNT_W-1:0] cnt_q; // Wait-state or post-delay counter
  reg wr_q; // Latched direction of current cycle
  reg [`MPB_CS_IDX_W-1:0] cs_q; // Latched chip select index
  reg [`MPB_PD_W-1:0] post_q; // Post delay sampled at request start
  wire head_write; // Head request is a write
  wire [`MPB_CS_IDX_W-1:0] head_cs; // Head request select index
  wire head_blocked; // Head write hits a protected select
  wire cycle_done; // Strobe phase may end now

  assign head_write = q_word[`MPB_REQ_WR_POS];
  assign head_cs = q_word[`MPB_REQ_CS_HI:`MPB_REQ_CS_LO];
  // Head select makes its bit low in the decode
  assign head_blocked = head_write &
    |(~cs_decode(head_cs) & i_cfg_write_protect);
  assign q_pop = q_valid & state_q[0];
  assign o_busy = ~state_q[0];

  // Wait mode runs on unless held; ack mode ends only when acknowledged
  assign cycle_done = i_cfg_ack_mode ? handshake_on : ~handshake_on;

  // State and counter
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      cnt_q <= `MPB_CNT_RST;
      wr_q <= 1'b0;
      cs_q <= {`MPB_CS_IDX_W{1'b0}};
      post_q <= {`MPB_PD_W{1'b0}};
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A protected write is dropped without touching the pins
          if (q_valid & ~head_blocked) begin
            state_q <= ST_SETUP;
            wr_q <= head_write;
            cs_q <= head_cs;
            post_q <= i_cfg_post_delay;
          end
        end
        ST_SETUP: begin
          // Strobe length covers the input synchroniser delay
          cnt_q <= {1'b0, i_cfg_wait_states} + `MPB_SYNC_SLACK;
          state_q <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_q != `MPB_CNT_RST) begin
            cnt_q <= cnt_q - 7'h01;
          end else begin
            state_q <= ST_HANDSHAKE;
          end
        end
        ST_HANDSHAKE: begin
          // No timeout: a device that never answers holds the bus
          if (cycle_done) begin
            cnt_q <= {2'b00, post_q};
            state_q <= (post_q == {`MPB_PD_W{1'b0}}) ? ST_IDLE : ST_POST;
          end
        end
        ST_POST: begin
          if (cnt_q == 7'h01) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - 7'h01;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Answers
  // ************************************************************

  // One-cycle answer for each finished cycle or refused write
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_write <= 1'b0;
      o_rsp_protect_err <= 1'b0;
      o_rsp_rdata <= `MPB_DATA_RST;
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_protect_err <= 1'b0;
      if (state_q[0] & q_valid & head_blocked) begin
        o_rsp_valid <= 1'b1;
        o_rsp_write <= 1'b1;
        o_rsp_protect_err <= 1'b1;
      end else if (state_q[3] & cycle_done) begin
        o_rsp_valid <= 1'b1;
        o_rsp_write <= wr_q;
        if (~wr_q) begin
          o_rsp_rdata <= data_sync;
        end
      end
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************

  reg active_d; // Cycle occupies the bus next
  reg strobe_d; // Strobe phase next
  always @* begin
    active_d = 1'b0;
    strobe_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        active_d = q_valid & ~head_blocked;
      end
      ST_SETUP: begin
        active_d = 1'b1;
        strobe_d = 1'b1;
      end
      ST_STROBE: begin
        active_d = 1'b1;
        strobe_d = 1'b1;
      end
      ST_HANDSHAKE: begin
        active_d = ~cycle_done;
        strobe_d = ~cycle_done;
      end
      default: begin
        active_d = 1'b0;
      end
    endcase
  end

  // Registered pins; address and write data load only at cycle start
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_mem_bus_address <= `MPB_ADDR_RST;
      o_mem_bus_address_hi <= {`MPB_HI_ADDR_W{1'b0}};
      o_mem_bus_data <= `MPB_DATA_RST;
      o_chip_select_low <= `MPB_CS_IDLE;
      o_read_not_write <= 1'b1;
      o_output_enable_low <= 1'b1;
      o_write_strobe_low <= 1'b1;
      o_xcvr_direction <= 1'b0;
      o_xcvr_enable_low <= 1'b1;
      o_mem_bus_data_oe <= 1'b0;
    end else begin
      if (state_q[0] & q_valid & ~head_blocked) begin
        // Full 26-bit offset inside each select, 64 MB apiece
        o_mem_bus_address <= q_word[`MPB_REQ_ADDR_LO+21:`MPB_REQ_ADDR_LO];
        o_mem_bus_address_hi <= q_word[`MPB_REQ_ADDR_HI:`MPB_REQ_ADDR_LO+22];
        o_mem_bus_data <= q_word[`MPB_REQ_DATA_HI:`MPB_REQ_DATA_LO];
        o_read_not_write <= ~head_write;
        o_xcvr_direction <= head_write;
      end
      o_chip_select_low <= active_d ?
        cs_decode(state_q[0] ? head_cs : cs_q) : `MPB_CS_IDLE;
      // Buffer open only inside a cycle, never during the post gap
      o_xcvr_enable_low <= ~active_d;
      o_mem_bus_data_oe <= active_d & (state_q[0] ? head_write : wr_q);
      o_output_enable_low <= ~(strobe_d & ~wr_q);
      o_write_strobe_low <= ~(strobe_d & wr_q);
    end
  end

endmodule // mpb_port

/* sim/mpb_port_props.sv */
// Pin checker for mpb_port, bound to every instance of it.
// Assumes one clock, synchronous active-high reset, wait/ack pin active low.
`timescale 1ns/10ps
module mpb_port_props (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_cfg_ack_mode,
  input wire [3:0] i_cfg_write_protect,
  input wire i_wait_or_ack_in,
  input wire o_rsp_valid,
  input wire o_rsp_write,
  input wire o_rsp_protect_err,
  input wire [21:0] o_mem_bus_address,
  input wire [3:0] o_mem_bus_address_hi,
  input wire [3:0] o_chip_select_low,
  input wire o_read_not_write,
  input wire o_output_enable_low,
  input wire o_write_strobe_low,
  input wire o_xcvr_direction,
  input wire o_xcvr_enable_low,
  input wire o_mem_bus_data_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire sel = o_chip_select_low != 4'hF; // A bus cycle is on the pins
  // Pin low long enough to have passed the three-flop filter
  sequence pin_held_low; !i_wait_or_ack_in [*5]; endsequence
  sequence strobe_open; $fell(o_output_enable_low); endsequence
  chk_reset_idle: assert property ($fell(i_srst) |-> !sel && !o_mem_bus_data_oe)
    else $error("pins busy at reset release");
  chk_read_oe: assert property (!o_output_enable_low |-> o_read_not_write && sel && !o_mem_bus_data_oe)
    else $error("output enable outside a read");
  chk_write_we: assert property (!o_write_strobe_low |-> !o_read_not_write && sel && o_mem_bus_data_oe)
    else $error("write strobe outside a write");
  chk_one_select: assert property (sel |-> $onehot(~o_chip_select_low))
    else $error("more than one select low");
  chk_xcvr_dir: assert property (!o_xcvr_enable_low |-> sel && o_xcvr_direction == !o_read_not_write)
    else $error("buffer direction wrong");
  chk_xcvr_idle: assert property (!sel |-> o_xcvr_enable_low)
    else $error("buffer enabled between cycles");
  chk_addr_hold: assert property (sel && $past(sel) |-> $stable({o_mem_bus_address_hi, o_mem_bus_address}))
    else $error("address moved inside a cycle");
  chk_min_strobe: assert property (strobe_open |-> !o_output_enable_low [*4])
    else $error("strobe too short");
  chk_wait_stretch: assert property ((pin_held_low ##0 (!i_cfg_ack_mode && !o_output_enable_low)) |=> !o_output_enable_low)
    else $error("cycle ended during wait");
  chk_ack_seen: assert property ($rose(o_output_enable_low) && i_cfg_ack_mode |-> !$past(i_wait_or_ack_in, 3))
    else $error("cycle ended without acknowledge");
  chk_protect_quiet: assert property (!o_write_strobe_low |-> (i_cfg_write_protect & ~o_chip_select_low) == 4'h0)
    else $error("write strobe on protected select");
  chk_protect_rsp: assert property (o_rsp_protect_err |-> o_rsp_valid && o_rsp_write)
    else $error("protect error without write answer");
endmodule // mpb_port_props
bind mpb_port mpb_port_props i_mpb_port_props (.*);

/* sim/mpb_mem_model.sv */
// Far-side memory: 64 bytes, wait/ack pin and data pin resolution.
// Assumes pins straight from mpb_port; the wait pin has a pull-up.
`timescale 1ns/10ps
module mpb_mem_model (
  input wire i_sys_clk,
  input wire [3:0] i_cs_low,
  input wire [21:0] i_addr,
  input wire [3:0] i_addr_hi,
  input wire i_rnw,
  input wire i_oe_low,
  input wire i_we_low,
  input wire [7:0] i_dev_data,
  input wire i_dev_oe,
  input wire i_ack_mode,
  input wire [7:0] i_hold,
  input wire i_boot_en,
  input wire [7:0] i_boot_vec,
  output reg [7:0] o_bus,
  output wire o_wait_ack_low,
  output reg [25:0] o_seen_addr
);
  reg [7:0] mem_q [0:63]; // Byte store on the low address bits
  reg [7:0] last_q; // Last level on the data pins
  reg [7:0] cnt_q; // Cycles since the strobe opened
  wire sel = i_cs_low != 4'hF;
  wire strobe = sel && !(i_oe_low && i_we_low);
  // Released pins show the inverse of their last level, never a kind value
  always @* begin
    if (i_dev_oe) o_bus = i_dev_data;
    else if (i_boot_en) o_bus = i_boot_vec;
    else if (sel && !i_oe_low && i_rnw) o_bus = mem_q[i_addr[5:0]];
    else o_bus = ~last_q;
  end
  // Wait holds the pin low early; acknowledge pulls it low late
  assign o_wait_ack_low = !strobe || (i_ack_mode ? cnt_q < i_hold : cnt_q >= i_hold);
  always @(posedge i_sys_clk) begin
    last_q <= o_bus;
    cnt_q <= strobe ? cnt_q + 8'h01 : 8'h00;
    if (sel) o_seen_addr <= {i_addr_hi, i_addr};
    if (sel && !i_we_low && !i_rnw) mem_q[i_addr[5:0]] <= o_bus;
  end
endmodule // mpb_mem_model

/* sim/testbench.sv */
// Bench for mpb_port against the far-side memory model.
// Assumes 50 MHz; inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module testbench;
  reg i_sys_clk = 1'b0, i_srst = 1'b1, i_req_valid = 1'b0, i_req_write = 1'b0;
  reg [1:0] i_req_cs = 2'h0;
  reg [25:0] i_req_addr = 26'h0;
  reg [7:0] i_req_wdata = 8'h00, hold = 8'h00;
  reg [5:0] i_cfg_wait_states = 6'h00;
  reg [4:0] i_cfg_post_delay = 5'h00;
  reg i_cfg_ack_mode = 1'b0, stalled = 1'b0, err = 1'b0;
  reg [3:0] i_cfg_write_protect = 4'h0;
  wire o_req_ready, o_rsp_valid, o_rsp_write, o_rsp_protect_err, o_busy, o_read_not_write;
  wire o_output_enable_low, o_write_strobe_low, o_xcvr_direction, o_xcvr_enable_low;
  wire o_mem_bus_data_oe, i_wait_or_ack_in;
  wire [7:0] o_rsp_rdata, o_boot_vector, i_mem_bus_data, o_mem_bus_data;
  wire [21:0] o_mem_bus_address;
  wire [3:0] o_mem_bus_address_hi, o_chip_select_low;
  wire [25:0] seen;
  int fail_count = 0, check_count = 0, cycles = 0, lat = 0, i, j;
  int wst[4] = '{0, 63, 5, 0};
  int pdt[4] = '{0, 0, 31, 1};
  always #10 i_sys_clk = ~i_sys_clk;
  mpb_port i_mpb_port (.*);
  mpb_mem_model i_mpb_mem_model (.i_sys_clk(i_sys_clk), .i_cs_low(o_chip_select_low),
    .i_addr(o_mem_bus_address), .i_addr_hi(o_mem_bus_address_hi), .i_rnw(o_read_not_write),
    .i_oe_low(o_output_enable_low), .i_we_low(o_write_strobe_low), .i_dev_data(o_mem_bus_data),
    .i_dev_oe(o_mem_bus_data_oe), .i_ack_mode(i_cfg_ack_mode), .i_hold(hold), .i_boot_en(i_srst),
    .i_boot_vec(8'hA5), .o_bus(i_mem_bus_data), .o_wait_ack_low(i_wait_or_ack_in),
    .o_seen_addr(seen));
  // ************************************
  // Access tasks
  // ************************************
  function automatic logic [25:0] adr(input logic [1:0] c);
    adr = {c, 2'h1, 16'hFFFF, c, 4'hA}; // Upper bits differ per select
  endfunction
  // Post delay seen by the next op: the bench spends two edges (idle edge and take)
  // before the next request reaches the sequencer, so only the excess shows
  function automatic int gap(input int p);
    gap = (p > 2) ? p - 2 : 0;
  endfunction
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Caller holds valid; fields change only after a take
  task put(input logic w, input logic [1:0] c, input logic [7:0] d);
    i_req_write = w;
    i_req_cs = c;
    i_req_addr = adr(c);
    i_req_wdata = d;
    while (o_req_ready !== 1'b1) begin
      stalled = 1'b1;
      @(posedge i_sys_clk) #1;
    end
    @(posedge i_sys_clk) #1;
  endtask
  task get;
    lat = 0;
    do begin
      @(posedge i_sys_clk) #1;
      lat++;
    end while (o_rsp_valid !== 1'b1 && lat < 3000);
    if (lat >= 3000) fail_count++; // A missing answer counts as a mismatch
    err = o_rsp_protect_err;
  endtask
  task op(input logic w, input logic [1:0] c, input logic [7:0] d);
    i_req_valid = 1'b1;
    put(w, c, d);
    i_req_valid = 1'b0;
    get;
    cmp("rsp_write", w, o_rsp_write);
    @(posedge i_sys_clk) #1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard well above the longest sequence
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    @(posedge i_sys_clk) #1;
    cmp("boot_vector", 8'hA5, o_boot_vector);
    cmp("selects", 4'hF, o_chip_select_low);
    for (i = 0; i < 4; i++) begin
      i_cfg_wait_states = 6'(wst[i]);
      i_cfg_post_delay = 5'(pdt[i]);
      op(1'b1, 2'(i), 8'hC0 | 8'(i));
      cmp("write_lat", wst[i] + gap(i > 0 ? pdt[i-1] : 0) + 7, lat);
      op(1'b0, 2'(i), 8'h00);
      cmp("read_lat", wst[i] + gap(pdt[i]) + 7, lat);
      cmp("read_data", 8'hC0 | 8'(i), o_rsp_rdata);
      cmp("address", adr(2'(i)), seen);
    end
    i_cfg_post_delay = 5'h00;
    hold = 8'h14;
    op(1'b0, 2'h0, 8'h00);
    cmp("wait_lat", 1, lat >= 25 && lat <= 32);
    i_cfg_ack_mode = 1'b1;
    hold = 8'h0A;
    op(1'b0, 2'h1, 8'h00);
    cmp("ack_lat", 1, lat >= 15 && lat <= 22);
    i_cfg_ack_mode = 1'b0;
    i_cfg_write_protect = 4'h4;
    op(1'b1, 2'h2, 8'h55);
    cmp("protect_err", 1, err);
    cmp("protect_lat", 1, lat);
    op(1'b0, 2'h2, 8'h00);
    cmp("protect_keep", 8'hC2, o_rsp_rdata);
    i_cfg_write_protect = 4'h0;
    i_cfg_ack_mode = 1'b1;
    hold = 8'h1E;
    fork
      begin
        i_req_valid = 1'b1;
        for (i = 0; i < 6; i++) put(1'b0, 2'(i), 8'h00);
        i_req_valid = 1'b0;
      end
      for (j = 0; j < 6; j++) begin
        get;
        cmp("queue_data", 8'hC0 | 8'(j % 4), o_rsp_rdata);
      end
    join
    cmp("queue_stall", 1, stalled);
    repeat (2) @(posedge i_sys_clk) #1;
    cmp("queue_empty", 1, o_req_ready && !o_busy);
    report_and_stop;
  end
endmodule // testbench
